/* File: sapm_cmd_select.sv */
// Control-mode decode and internal command source selection.
`timescale 1ns/1ps
module sapm_cmd_select (
    input wire logic [7:0] mode_code,
    input wire logic speed_select_in0,
    input wire logic speed_select_in1,
    input wire logic torque_select_in0,
    input wire logic torque_select_in1,
    output sapm_pkg::sapm_cmd_t cmd
);
    import sapm_pkg::*;

    // Decode the mode and pick the command source from the inputs.
    always_comb begin
        cmd = '0;
        case (mode_code)
            MODE_SPEED: begin
                cmd.mode = SAPM_MODE_SPEED;
                cmd.cmd_index = {speed_select_in1, speed_select_in0};
            end
            MODE_TORQUE: begin
                cmd.mode = SAPM_MODE_TORQUE;
                cmd.cmd_index = {torque_select_in1, torque_select_in0};
            end
            MODE_NET: begin
                cmd.mode = SAPM_MODE_NET;
            end
            default: begin
                cmd.mode = SAPM_MODE_NONE;
            end
        endcase
        // Index zero means the zero-speed command in both internal modes.
        cmd.zero_cmd = (cmd.mode == SAPM_MODE_SPEED || cmd.mode == SAPM_MODE_TORQUE)
            && (cmd.cmd_index == 2'b00);
    end
endmodule

/* File: sapm_host.sv */
// Host model that speaks Avalon-MM to the parameter registers.
`timescale 1ns/1ps
module sapm_host (
    input wire logic core_clk,
    output logic [9:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [15:0] avs_writedata,
    output logic [1:0] avs_byteenable,
    input wire logic [15:0] avs_readdata,
    input wire logic avs_waitrequest
);
    initial begin
        avs_address = 10'h000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 16'h0000;
        avs_byteenable = 2'b11;
    end
    // One word transfer; the request stands until waitrequest is sampled low.
    task automatic xfer(input logic wr, input logic [9:0] a, input logic [15:0] wd,
                        output logic [15:0] rd);
        repeat ($urandom_range(2)) @(posedge core_clk);
        @(posedge core_clk);
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= wd;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // Released lines show the inverse, so a stale value never looks valid.
        avs_writedata <= ~wd;
        avs_address <= ~a;
    endtask
    // A 32-bit value travels low word first, at the even address.
    task automatic rd32(input logic [9:0] a, output logic [31:0] v);
        logic [15:0] l, h;
        xfer(1'b0, a, 16'h0000, l);
        xfer(1'b0, a + 10'h001, 16'h0000, h);
        v = {h, l};
    endtask
    task automatic wr32(input logic [9:0] a, input logic [31:0] v);
        logic [15:0] d;
        xfer(1'b1, a, v[15:0], d);
        xfer(1'b1, a + 10'h001, v[31:16], d);
    endtask
endmodule

/* File: sapm_ms_tick.sv */
// Millisecond tick generator for the monitor hold filter.
`timescale 1ns/1ps
module sapm_ms_tick #(
    parameter int CYCLES = sapm_pkg::CYC_PER_MS
) (
    input wire logic core_clk,
    input wire logic rst_n,
    output logic tick
);
    import sapm_pkg::*;

    // Counter of clock cycles within one millisecond.
    logic [31:0] cnt_ff;

    // Count up and pulse once per millisecond.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 32'h0;
            tick <= 1'b0;
        end else if (cnt_ff == 32'(CYCLES - 1)) begin
            cnt_ff <= 32'h0;
            tick <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 32'h1;
            tick <= 1'b0;
        end
    end
endmodule

/* File: sapm_pkg.sv */
// Package of constants and types for the absolute position monitor and mode block.
package sapm_pkg;

    // Word addresses of the 16-bit parameter words.
    localparam logic [9:0] ADDR_TURN_LO = 10'h066;
    localparam logic [9:0] ADDR_TURN_HI = 10'h067;
    localparam logic [9:0] ADDR_SINGLE_LO = 10'h068;
    localparam logic [9:0] ADDR_SINGLE_HI = 10'h069;
    localparam logic [9:0] ADDR_FILT = 10'h06a;
    localparam logic [9:0] ADDR_FILT_HI = 10'h06b;
    localparam logic [9:0] ADDR_LOWER_LO = 10'h06c;
    localparam logic [9:0] ADDR_LOWER_HI = 10'h06d;
    localparam logic [9:0] ADDR_UPPER_LO = 10'h06e;
    localparam logic [9:0] ADDR_UPPER_HI = 10'h06f;
    localparam logic [9:0] ADDR_MODE = 10'h102;
    localparam logic [9:0] ADDR_MODE_HI = 10'h103;
    localparam logic [9:0] ADDR_UNIT_SEL = 10'h140;

    // Field positions and reset values.
    localparam int FILT_MS_LSB = 0;
    localparam int FILT_MS_W = 4;
    localparam logic [15:0] FILT_MAX = 16'h000f;
    localparam int UNIT_SEL_BIT = 1;
    localparam logic [15:0] FILT_RESET = 16'h0000;
    localparam logic [31:0] BOUND_RESET = 32'h0000_0000;
    localparam logic [15:0] MODE_RESET = 16'h0004;
    localparam logic [15:0] UNIT_SEL_RESET = 16'h0000;

    // Mode codes held in the low byte of the mode word.
    localparam logic [7:0] MODE_SPEED = 8'h04;
    localparam logic [7:0] MODE_TORQUE = 8'h05;
    localparam logic [7:0] MODE_NET = 8'h0b;

    // Per-turn resolution and millisecond tick derivation.
    localparam int TURN_RES = 1280000;
    localparam int CLK_MHZ = 100;
    localparam int MS_PER_TICK = 1;
    localparam int CYC_PER_MS = MS_PER_TICK * CLK_MHZ * 1000;

    // Decoded operating mode.
    typedef enum logic [1:0] {
        SAPM_MODE_NONE,
        SAPM_MODE_SPEED,
        SAPM_MODE_TORQUE,
        SAPM_MODE_NET
    } sapm_mode_t;

    // Command source selection handed to the drive core.
    typedef struct packed {
        sapm_mode_t mode;
        logic zero_cmd;
        logic [1:0] cmd_index;
    } sapm_cmd_t;

    // Encoder absolute position sample.
    typedef struct packed {
        logic signed [15:0] turns;
        logic [31:0] pulses;
        logic signed [31:0] user_pos;
    } sapm_pos_t;

endpackage

/* File: sapm_properties.sv */
// Checker of bus timing, readout and command selection at the top ports.
`timescale 1ns/1ps
module sapm_properties
    import sapm_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [15:0] avs_writedata,
    input wire logic [15:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic signed [31:0] first_monitored_variable,
    input wire logic speed_select_in0,
    input wire logic speed_select_in1,
    input wire logic torque_select_in0,
    input wire logic torque_select_in1,
    input wire logic signed [31:0] monitor_out,
    input wire sapm_pkg::sapm_cmd_t cmd_out
);
    logic unit_ff; // Shadow of the unit-select bit, so turn reads can be judged.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // Track the unit choice at the write answer edge, the only edge a write lands.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            unit_ff <= 1'b0;
        end else if (avs_write && !avs_waitrequest && avs_address == ADDR_UNIT_SEL) begin
            unit_ff <= avs_writedata[UNIT_SEL_BIT];
        end
    end
    property p_one_low; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_one_low: assert property (p_one_low) else $error("waitrequest low too long");
    property p_answer; $rose(avs_read || avs_write) |=> !avs_waitrequest; endproperty
    a_answer: assert property (p_answer) else $error("answer not one cycle late");
    property p_no_spur; !avs_waitrequest |-> $past(avs_read || avs_write); endproperty
    a_no_spur: assert property (p_no_spur) else $error("answer without request");
    property p_unmapped;
        avs_read && !avs_waitrequest && avs_address == 10'h200 |-> avs_readdata == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_turn_zero;
        avs_read && !avs_waitrequest && unit_ff && avs_address[9:1] == ADDR_TURN_LO[9:1]
            |-> avs_readdata == 16'h0000;
    endproperty
    a_turn_zero: assert property (p_turn_zero) else $error("turn count not zero");
    property p_speed;
        cmd_out.mode == SAPM_MODE_SPEED && $stable({speed_select_in1, speed_select_in0})
            |-> cmd_out.cmd_index == {speed_select_in1, speed_select_in0};
    endproperty
    a_speed: assert property (p_speed) else $error("speed select wrong");
    property p_torque;
        cmd_out.mode == SAPM_MODE_TORQUE && $stable({torque_select_in1, torque_select_in0})
            |-> cmd_out.cmd_index == {torque_select_in1, torque_select_in0};
    endproperty
    a_torque: assert property (p_torque) else $error("torque select wrong");
    property p_zero;
        cmd_out.mode inside {SAPM_MODE_SPEED, SAPM_MODE_TORQUE}
            |-> cmd_out.zero_cmd == (cmd_out.cmd_index == 2'b00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero command flag wrong");
    property p_mon_src;
        $changed(monitor_out) |-> monitor_out == $past(first_monitored_variable);
    endproperty
    a_mon_src: assert property (p_mon_src) else $error("monitor output from nowhere");
    cover property (avs_write && !avs_waitrequest);
    cover property (cmd_out.mode == SAPM_MODE_TORQUE);
    cover property (cmd_out.mode == SAPM_MODE_NET);
    cover property ($changed(monitor_out));
endmodule

/* File: sapm_top.sv */
// Parameter registers, position readout, windowed hold filter and mode select.
`timescale 1ns/1ps
module sapm_top #(
    parameter int TICK_CYCLES = sapm_pkg::CYC_PER_MS,
    parameter int RESOLUTION = sapm_pkg::TURN_RES
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [15:0] avs_writedata,
    input wire logic [1:0] avs_byteenable,
    output logic [15:0] avs_readdata,
    output logic avs_waitrequest,
    input wire sapm_pkg::sapm_pos_t enc_pos,
    input wire logic signed [31:0] first_monitored_variable,
    input wire logic speed_select_in0,
    input wire logic speed_select_in1,
    input wire logic torque_select_in0,
    input wire logic torque_select_in1,
    output logic signed [31:0] monitor_out,
    output sapm_pkg::sapm_cmd_t cmd_out
);
    import sapm_pkg::*;

    // Reset synchroniser stages; the second one resets the design.
    logic rst_meta_ff;
    logic rst_n_ff;
    // Software-written parameters.
    logic [15:0] filt_ff;
    logic signed [31:0] lower_ff;
    logic signed [31:0] upper_ff;
    logic [15:0] mode_ff;
    logic [15:0] unit_sel_ff;
    // Bus handshake state: one wait cycle, then the answer cycle.
    logic ack_ff;
    // Hold filter state.
    logic [3:0] hold_cnt_ff;
    logic signed [31:0] last_in_ff;
    logic pending_ff;
    // Position readout values and decoded command.
    logic [31:0] turn_val;
    logic [31:0] single_val;
    logic [15:0] nxt_rdata;
    logic ms_tick;
    logic in_window;
    logic user_units;
    sapm_cmd_t cmd_now;

    // Release reset through two flip-flops so the design leaves reset cleanly.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    // Millisecond time base for the filter.
    sapm_ms_tick #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .core_clk(core_clk),
        .rst_n(rst_n_ff),
        .tick(ms_tick)
    );

    // Mode decode and command source selection.
    sapm_cmd_select u_sel (
        .mode_code(mode_ff[7:0]),
        .speed_select_in0(speed_select_in0),
        .speed_select_in1(speed_select_in1),
        .torque_select_in0(torque_select_in0),
        .torque_select_in1(torque_select_in1),
        .cmd(cmd_now)
    );

    // Merge a 16-bit write into the selected half of a 32-bit value.
    function automatic logic [31:0] put_half(input logic [31:0] old, input logic hi,
                                             input logic [15:0] wd, input logic [1:0] be);
        logic [15:0] half;
        half = hi ? old[31:16] : old[15:0];
        if (be[0]) begin
            half[7:0] = wd[7:0];
        end
        if (be[1]) begin
            half[15:8] = wd[15:8];
        end
        return hi ? {half, old[15:0]} : {old[31:16], half};
    endfunction

    // Merge a 16-bit write into a 16-bit register under byte enables.
    // A function result cannot be part-selected, so the merge lands in a local first.
    function automatic logic [15:0] put_word(input logic [15:0] old, input logic [15:0] wd,
                                             input logic [1:0] be);
        logic [31:0] merged;
        merged = put_half({16'h0, old}, 1'b0, wd, be);
        return merged[15:0];
    endfunction

    // The unit-select bit picks pulses or user units.
    assign user_units = unit_sel_ff[UNIT_SEL_BIT];

    // Turn count: sign-extended turns in pulse mode, zero in user units.
    always_comb begin
        if (user_units) begin
            turn_val = 32'h0;
        end else begin
            turn_val = {{16{enc_pos.turns[15]}}, enc_pos.turns};
        end
    end

    // Single-turn value: clamped pulse count or signed user position.
    always_comb begin
        if (user_units) begin
            single_val = enc_pos.user_pos;
        end else if (enc_pos.pulses >= 32'(RESOLUTION)) begin
            single_val = 32'(RESOLUTION - 1);
        end else begin
            single_val = enc_pos.pulses;
        end
    end

    // Read multiplexer; unmapped words read as zero.
    always_comb begin
        case (avs_address)
            ADDR_TURN_LO: nxt_rdata = turn_val[15:0];
            ADDR_TURN_HI: nxt_rdata = turn_val[31:16];
            ADDR_SINGLE_LO: nxt_rdata = single_val[15:0];
            ADDR_SINGLE_HI: nxt_rdata = single_val[31:16];
            ADDR_FILT: nxt_rdata = filt_ff;
            ADDR_LOWER_LO: nxt_rdata = lower_ff[15:0];
            ADDR_LOWER_HI: nxt_rdata = lower_ff[31:16];
            ADDR_UPPER_LO: nxt_rdata = upper_ff[15:0];
            ADDR_UPPER_HI: nxt_rdata = upper_ff[31:16];
            ADDR_MODE: nxt_rdata = mode_ff;
            ADDR_UNIT_SEL: nxt_rdata = unit_sel_ff;
            default: nxt_rdata = 16'h0;
        endcase
    end

    // Bus handshake: waitrequest is high until the answer cycle.
    // A fixed one-cycle wait keeps read data registered and outputs flop-driven.
    always_ff @(posedge core_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            ack_ff <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 16'h0;
        end else if ((avs_read || avs_write) && !ack_ff) begin
            ack_ff <= 1'b1;
            avs_waitrequest <= 1'b0;
            avs_readdata <= nxt_rdata;
        end else begin
            ack_ff <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= avs_readdata;
        end
    end

    // Register writes take effect on the answer edge only.
    always_ff @(posedge core_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            filt_ff <= FILT_RESET;
            lower_ff <= BOUND_RESET;
            upper_ff <= BOUND_RESET;
            mode_ff <= MODE_RESET;
            unit_sel_ff <= UNIT_SEL_RESET;
        end else if (avs_write && ack_ff) begin
            case (avs_address)
                ADDR_FILT: begin
                    // Values above the maximum are refused and leave the register as is.
                    if (put_word(filt_ff, avs_writedata, avs_byteenable) <= FILT_MAX) begin
                        filt_ff <= put_word(filt_ff, avs_writedata, avs_byteenable);
                    end
                end
                ADDR_LOWER_LO, ADDR_LOWER_HI: begin
                    lower_ff <= put_half(lower_ff, avs_address[0], avs_writedata,
                                         avs_byteenable);
                end
                ADDR_UPPER_LO, ADDR_UPPER_HI: begin
                    upper_ff <= put_half(upper_ff, avs_address[0], avs_writedata,
                                         avs_byteenable);
                end
                ADDR_MODE: mode_ff <= put_word(mode_ff, avs_writedata, avs_byteenable);
                ADDR_UNIT_SEL: begin
                    unit_sel_ff <= put_word(unit_sel_ff, avs_writedata, avs_byteenable);
                end
                default: begin
                    // Read-only and unmapped words ignore writes.
                end
            endcase
        end
    end

    // Window test on the first monitored variable, bounds inclusive.
    assign in_window = (first_monitored_variable >= lower_ff)
        && (first_monitored_variable <= upper_ff);

    // Hold filter: outside the window the output follows at once; inside it
    // a change is published once the filter time's number of millisecond ticks has passed.
    // A zero filter time passes changes straight through.
    always_ff @(posedge core_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            monitor_out <= 32'sh0;
            last_in_ff <= 32'sh0;
            hold_cnt_ff <= 4'h0;
            pending_ff <= 1'b0;
        end else begin
            last_in_ff <= first_monitored_variable;
            if (!in_window || filt_ff[FILT_MS_LSB +: FILT_MS_W] == 4'h0) begin
                monitor_out <= first_monitored_variable;
                pending_ff <= 1'b0;
                hold_cnt_ff <= 4'h0;
            end else if (first_monitored_variable != last_in_ff) begin
                // A new change restarts the hold time.
                pending_ff <= 1'b1;
                hold_cnt_ff <= 4'h0;
            end else if (pending_ff && ms_tick) begin
                if (hold_cnt_ff + 4'h1 >= filt_ff[FILT_MS_LSB +: FILT_MS_W]) begin
                    monitor_out <= first_monitored_variable;
                    pending_ff <= 1'b0;
                    hold_cnt_ff <= 4'h0;
                end else begin
                    hold_cnt_ff <= hold_cnt_ff + 4'h1;
                end
            end
        end
    end

    // Registered command selection toward the drive core.
    always_ff @(posedge core_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            cmd_out <= '0;
        end else begin
            cmd_out <= cmd_now;
        end
    end
endmodule

/* File: tb_sapm_top.sv */
// Self-checking bench of the position monitor and mode block.
`timescale 1ns/1ps
module tb_sapm_top;
    import sapm_pkg::*;
    localparam int TK = 10; // Short millisecond so hold times stay cheap.
    localparam int RES = TURN_RES;
    logic core_clk, resetn, avs_read, avs_write, avs_waitrequest;
    logic [9:0] avs_address;
    logic [15:0] avs_writedata, avs_readdata;
    logic [1:0] avs_byteenable;
    sapm_pos_t enc_pos;
    logic signed [31:0] first_monitored_variable, monitor_out;
    logic speed_select_in0, speed_select_in1, torque_select_in0, torque_select_in1;
    sapm_cmd_t cmd_out;
    int err_total, checks;
    // The last code is undefined, so the no-mode branch of the decode is reached too.
    logic [7:0] codes [4] = '{MODE_SPEED, MODE_TORQUE, MODE_NET, 8'h07};
    sapm_top #(.TICK_CYCLES(TK), .RESOLUTION(RES)) sapm_top_i (.core_clk, .resetn,
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .enc_pos, .first_monitored_variable,
        .speed_select_in0, .speed_select_in1, .torque_select_in0, .torque_select_in1,
        .monitor_out, .cmd_out);
    sapm_host sapm_host_i (.core_clk, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Single-turn readout: pulses clamp below one turn, user units pass whole.
    function automatic logic [31:0] exp_single(input logic usr, input sapm_pos_t p);
        if (usr) return p.user_pos;
        return (p.pulses >= RES) ? RES - 1 : p.pulses;
    endfunction
    // Command source: d holds speed inputs high, torque inputs low.
    // Outside the two internal modes no select input matters.
    function automatic logic [2:0] exp_cmd(input logic [7:0] c, input logic [3:0] d);
        logic [1:0] i;
        i = (c == MODE_SPEED) ? d[3:2] : (c == MODE_TORQUE) ? d[1:0] : 2'b00;
        return (c == MODE_SPEED || c == MODE_TORQUE) ? {i == 2'b00, i} : 3'b000;
    endfunction
    // Mode decode: only the three defined codes select a mode.
    function automatic sapm_mode_t exp_mode(input logic [7:0] c);
        case (c)
            MODE_SPEED: return SAPM_MODE_SPEED;
            MODE_TORQUE: return SAPM_MODE_TORQUE;
            MODE_NET: return SAPM_MODE_NET;
            default: return SAPM_MODE_NONE;
        endcase
    endfunction
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Watchdog: the whole sequence needs a few hundred cycles.
    initial begin
        #200000;
        err_total++;
        end_of_test();
    end
    initial begin
        logic [15:0] r;
        logic [31:0] v;
        logic [3:0] d;
        int k;
        resetn = 1'b0;
        enc_pos = '0;
        first_monitored_variable = 32'sh0;
        {speed_select_in1, speed_select_in0, torque_select_in1, torque_select_in0} = 4'h0;
        void'($urandom(95));
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        sapm_host_i.rd32(ADDR_LOWER_LO, v); chk(v, BOUND_RESET);
        sapm_host_i.rd32(ADDR_UPPER_LO, v); chk(v, BOUND_RESET);
        sapm_host_i.xfer(1'b0, ADDR_FILT, 16'h0000, r); chk(r, FILT_RESET);
        sapm_host_i.xfer(1'b0, ADDR_MODE, 16'h0000, r); chk(r, MODE_RESET);
        sapm_host_i.xfer(1'b0, 10'h200, 16'h0000, r); chk(r, 32'h0);
        // Readout in both units, extreme turn count first, over-range pulses on the third pass.
        for (k = 0; k < 8; k++) begin
            enc_pos.turns <= (k == 0) ? 16'h8000 : 16'($urandom);
            enc_pos.pulses <= (k == 2) ? RES + 5 : (k == 0) ? RES - 1 : $urandom_range(RES - 1);
            enc_pos.user_pos <= $urandom;
            sapm_host_i.xfer(1'b1, ADDR_UNIT_SEL, {14'h0, k[0], 1'b0}, r);
            sapm_host_i.xfer(1'b1, ADDR_SINGLE_LO, 16'($urandom), r);
            sapm_host_i.rd32(ADDR_TURN_LO, v);
            chk(v, k[0] ? 32'h0 : {{16{enc_pos.turns[15]}}, enc_pos.turns});
            sapm_host_i.rd32(ADDR_SINGLE_LO, v); chk(v, exp_single(k[0], enc_pos));
        end
        // Over-range filter time is refused, a legal one is kept.
        sapm_host_i.xfer(1'b1, ADDR_FILT, 16'h0010, r);
        sapm_host_i.xfer(1'b0, ADDR_FILT, 16'h0000, r); chk(r, FILT_RESET);
        sapm_host_i.xfer(1'b1, ADDR_FILT, 16'h0003, r);
        sapm_host_i.xfer(1'b0, ADDR_FILT, 16'h0000, r); chk(r, 32'h3);
        sapm_host_i.wr32(ADDR_LOWER_LO, -32'sd100);
        sapm_host_i.wr32(ADDR_UPPER_LO, 32'sd100);
        sapm_host_i.rd32(ADDR_LOWER_LO, v); chk(v, -32'sd100);
        // Outside passes at once; the inclusive edge value is held for 2 to 3 ms.
        first_monitored_variable <= 32'sd500;
        repeat (4) @(posedge core_clk); chk(monitor_out, 32'sd500);
        first_monitored_variable <= 32'sd100;
        repeat (4) @(posedge core_clk); chk(monitor_out, 32'sd500);
        repeat (32) @(posedge core_clk); chk(monitor_out, 32'sd100);
        // Every mode code with random select inputs, the undefined one included.
        for (k = 0; k < 12; k++) begin
            d = 4'($urandom);
            {speed_select_in1, speed_select_in0, torque_select_in1, torque_select_in0} <= d;
            sapm_host_i.xfer(1'b1, ADDR_MODE, {8'h00, codes[k % 4]}, r);
            repeat (3) @(posedge core_clk);
            chk(cmd_out.mode, exp_mode(codes[k % 4]));
            chk({cmd_out.zero_cmd, cmd_out.cmd_index}, exp_cmd(codes[k % 4], d));
        end
        // A reset in mid-run brings the bounds back and reopens the pass-through.
        resetn <= 1'b0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        sapm_host_i.rd32(ADDR_LOWER_LO, v);
        chk(v, BOUND_RESET);
        chk(monitor_out, 32'sd100);
        end_of_test();
    end
endmodule
bind sapm_top sapm_properties sapm_properties_i (.core_clk, .resetn, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .first_monitored_variable,
    .speed_select_in0, .speed_select_in1, .torque_select_in0, .torque_select_in1,
    .monitor_out, .cmd_out);
